// ===== rtl/pcefs_pkg.sv
/*
 * Constants for the channel enable, sequencing, reset mapping and fault
 * status register bank. Assumes an 8-bit register port from the serial
 * management front end and a 100 MHz system clock.
 */
package pcefs_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_CHANNEL_ENABLE   = 8'h05;
	localparam logic [7:0] ADDR_TURN_ON_HIGH     = 8'h06;
	localparam logic [7:0] ADDR_TURN_ON_LOW      = 8'h07;
	localparam logic [7:0] ADDR_RESET_MAPPING    = 8'h08;
	localparam logic [7:0] ADDR_LOW_V_STATUS     = 8'h0a;
	localparam logic [7:0] ADDR_HIGH_V_STATUS    = 8'h0b;
	localparam logic [7:0] ADDR_SHUTDOWN_STATUS  = 8'h0c;
	// ==========================================================
	// writable masks and reset values
	localparam logic [7:0] MASK_CHANNEL_ENABLE   = 8'h3d;
	localparam logic [7:0] MASK_RESET_MAPPING    = 8'h3f;
	localparam logic [7:0] MASK_CHANNEL_BITS     = 8'h3e;
	localparam logic [7:0] RST_CHANNEL_ENABLE    = 8'h3d;
	localparam logic [7:0] RST_TURN_ON_HIGH      = 8'h00;
	localparam logic [7:0] RST_TURN_ON_LOW       = 8'h11;
	localparam logic [7:0] RST_RESET_MAPPING     = 8'h3f;
	// ==========================================================
	// field positions
	localparam int ALL_ENABLE_BIT   = 0;
	localparam int WATCHDOG_MAP_BIT = 0;
	localparam int SUMMARY_BIT      = 7;
	localparam int HI_NIBBLE_LSB    = 4;
	// ==========================================================
	// timing, in microseconds and cycles at 100 MHz
	localparam int CLK_MHZ          = 100;
	localparam int STEP_0_US        = 500;
	localparam int STEP_1_US        = 1000;
	localparam int STEP_2_US        = 2500;
	localparam int STEP_3_US        = 5000;
	localparam int STEP_0_CYCLES    = STEP_0_US * CLK_MHZ;
	localparam int STEP_1_CYCLES    = STEP_1_US * CLK_MHZ;
	localparam int STEP_2_CYCLES    = STEP_2_US * CLK_MHZ;
	localparam int STEP_3_CYCLES    = STEP_3_US * CLK_MHZ;
	localparam int FILT_FINE_US     = 2;
	localparam int FILT_COARSE_US   = 10;
	localparam int FILT_FINE_CYCLES = FILT_FINE_US * CLK_MHZ;
	localparam int FILT_COARSE_CYC  = FILT_COARSE_US * CLK_MHZ;
	typedef enum logic [1:0] {PCEFS_SEQ_IDLE, PCEFS_SEQ_RUN, PCEFS_SEQ_DONE} pcefs_seq_t;
endpackage : pcefs_pkg

// ===== rtl/pcefs_regs.sv
/*
 * Register bank: channel enables, turn-on sequencer, reset mapping and
 * read-to-clear fault status. Assumes comparator inputs are asynchronous
 * levels and that the register port is synchronous to clk_sys.
 */
`timescale 1ns/1ps
module pcefs_regs (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       safe_hold_state,
	input  wire logic       sequence_start,
	input  wire logic [1:0] delay_step_select,
	input  wire logic [4:0] glitch_filter_count,
	input  wire logic       glitch_filter_step,
	input  wire logic [5:1] low_cmp,
	input  wire logic [5:1] high_cmp,
	input  wire logic [5:1] shutdown_cmp,
	input  wire logic       watchdog_error,
	output logic      [5:1] out_on,
	output logic            system_reset_output_n
);
	import pcefs_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [15:0] sync1_q;
	logic [15:0] sync2_q;
	logic [5:1]  low_s;
	logic [5:1]  high_s;
	logic [5:1]  off_s;
	logic        wd_s;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
		end
		else
		begin
			sync1_q <= {watchdog_error, shutdown_cmp, high_cmp, low_cmp};
			sync2_q <= sync1_q;
		end
	end
	assign low_s  = sync2_q[4:0];
	assign high_s = sync2_q[9:5];
	assign off_s  = sync2_q[14:10];
	assign wd_s   = sync2_q[15];

	// ==========================================================
	// configuration registers
	logic [7:0] en_q;
	logic [7:0] dly_hi_q;
	logic [7:0] dly_lo_q;
	logic [7:0] map_q;
	logic       safe_q;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			en_q     <= RST_CHANNEL_ENABLE;
			dly_hi_q <= RST_TURN_ON_HIGH;
			dly_lo_q <= RST_TURN_ON_LOW;
			map_q    <= RST_RESET_MAPPING;
			safe_q   <= 1'b0;
		end
		else
		begin
			safe_q <= safe_hold_state;
			if (reg_wr && reg_addr == ADDR_CHANNEL_ENABLE)
				en_q <= reg_wdata & MASK_CHANNEL_ENABLE;
			if (reg_wr && reg_addr == ADDR_TURN_ON_HIGH)
				dly_hi_q <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_TURN_ON_LOW)
				dly_lo_q <= reg_wdata;
			if (reg_wr && reg_addr == ADDR_RESET_MAPPING)
				map_q <= reg_wdata & MASK_RESET_MAPPING;
			// entry edge wins over a same-cycle host write
			if (safe_hold_state && !safe_q)
				en_q[5:2] <= 4'hf;
		end
	end

	// ==========================================================
	// glitch filter on summary flags
	logic [9:0]  tick_cnt_q;
	logic [4:0]  low_cnt_q;
	logic [4:0]  high_cnt_q;
	logic        low_filt_q;
	logic        high_filt_q;
	logic        tick;
	logic        low_raw;
	logic        high_raw;
	logic [9:0]  tick_max;
	assign tick_max = glitch_filter_step ? 10'(FILT_COARSE_CYC - 1)
	                                     : 10'(FILT_FINE_CYCLES - 1);
	// >= so a step change from coarse to fine cannot skip the wrap point
	assign tick     = (tick_cnt_q >= tick_max);
	// bit 1 of the enable register is reserved; channel 1 follows the all enable
	assign low_raw  = |(low_s & {en_q[5:2], en_q[ALL_ENABLE_BIT]});
	assign high_raw = |(high_s & {en_q[5:2], en_q[ALL_ENABLE_BIT]});
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			tick_cnt_q  <= 10'h000;
			low_cnt_q   <= 5'h00;
			high_cnt_q  <= 5'h00;
			low_filt_q  <= 1'b0;
			high_filt_q <= 1'b0;
		end
		else
		begin
			tick_cnt_q <= tick ? 10'h000 : tick_cnt_q + 10'h001;
			// the fault must persist count ticks before it is believed
			if (!low_raw)
			begin
				low_cnt_q  <= 5'h00;
				low_filt_q <= 1'b0;
			end
			else if (low_cnt_q >= glitch_filter_count)
				low_filt_q <= 1'b1;
			else if (tick)
				low_cnt_q <= low_cnt_q + 5'h01;
			if (!high_raw)
			begin
				high_cnt_q  <= 5'h00;
				high_filt_q <= 1'b0;
			end
			else if (high_cnt_q >= glitch_filter_count)
				high_filt_q <= 1'b1;
			else if (tick)
				high_cnt_q <= high_cnt_q + 5'h01;
		end
	end

	// ==========================================================
	// read-to-clear status; a set in the read cycle survives
	logic [7:0] low_st_q;
	logic [7:0] high_st_q;
	logic [7:0] off_st_q;
	logic [7:0] low_set;
	logic [7:0] high_set;
	logic [7:0] off_set;
	assign low_set  = {low_filt_q, 1'b0, low_s, 1'b0};
	assign high_set = {high_filt_q, 1'b0, high_s, 1'b0};
	assign off_set  = {2'b00, off_s, 1'b0};
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			low_st_q  <= 8'h00;
			high_st_q <= 8'h00;
			off_st_q  <= 8'h00;
		end
		else
		begin
			low_st_q  <= ((reg_rd && reg_addr == ADDR_LOW_V_STATUS) ? 8'h00 : low_st_q)
			             | low_set;
			high_st_q <= ((reg_rd && reg_addr == ADDR_HIGH_V_STATUS) ? 8'h00 : high_st_q)
			             | high_set;
			off_st_q  <= ((reg_rd && reg_addr == ADDR_SHUTDOWN_STATUS) ? 8'h00 : off_st_q)
			             | off_set;
		end
	end

	// ==========================================================
	// read data, registered; unmapped and reserved read zero
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_CHANNEL_ENABLE:  reg_rdata <= en_q;
				ADDR_TURN_ON_HIGH:    reg_rdata <= dly_hi_q;
				ADDR_TURN_ON_LOW:     reg_rdata <= dly_lo_q;
				ADDR_RESET_MAPPING:   reg_rdata <= map_q;
				ADDR_LOW_V_STATUS:    reg_rdata <= low_st_q;
				ADDR_HIGH_V_STATUS:   reg_rdata <= high_st_q;
				ADDR_SHUTDOWN_STATUS: reg_rdata <= off_st_q;
				default:              reg_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// turn-on sequencer; 19-bit step count covers the 5 ms step
	pcefs_seq_t  seq_q;
	logic [18:0] step_cnt_q;
	logic [3:0]  elapsed_q;
	logic [18:0] step_max;
	logic [3:0]  dly [2:5];
	assign dly[5] = dly_hi_q[7:HI_NIBBLE_LSB];
	assign dly[4] = dly_hi_q[HI_NIBBLE_LSB-1:0];
	assign dly[3] = dly_lo_q[7:HI_NIBBLE_LSB];
	assign dly[2] = dly_lo_q[HI_NIBBLE_LSB-1:0];
	always_comb
	begin
		unique case (delay_step_select)
			2'b00: step_max = 19'(STEP_0_CYCLES - 1);
			2'b01: step_max = 19'(STEP_1_CYCLES - 1);
			2'b10: step_max = 19'(STEP_2_CYCLES - 1);
			2'b11: step_max = 19'(STEP_3_CYCLES - 1);
		endcase
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			seq_q      <= PCEFS_SEQ_IDLE;
			step_cnt_q <= 19'h00000;
			elapsed_q  <= 4'h0;
		end
		else if (sequence_start)
		begin
			seq_q      <= PCEFS_SEQ_RUN;
			step_cnt_q <= 19'h00000;
			elapsed_q  <= 4'h0;
		end
		else if (seq_q == PCEFS_SEQ_RUN)
		begin
			if (step_cnt_q >= step_max)
			begin
				step_cnt_q <= 19'h00000;
				if (elapsed_q == 4'hf)
					seq_q <= PCEFS_SEQ_DONE;
				else
					elapsed_q <= elapsed_q + 4'h1;
			end
			else
				step_cnt_q <= step_cnt_q + 19'h00001;
		end
	end

	// ==========================================================
	// outputs; host may toggle enables in normal run, a cleared enable drops its output the next cycle
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			out_on <= 5'h00;
		else
		begin
			out_on[1] <= en_q[ALL_ENABLE_BIT];
			for (int c = 2; c <= 5; c++)
				out_on[c] <= en_q[ALL_ENABLE_BIT] && en_q[c] && seq_q != PCEFS_SEQ_IDLE
				             && (seq_q == PCEFS_SEQ_DONE || elapsed_q >= dly[c]);
		end
	end
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			system_reset_output_n <= 1'b1;
		else
			system_reset_output_n <= !(|((low_s | high_s) & map_q[5:1])
			                           || (wd_s && map_q[WATCHDOG_MAP_BIT]));
	end

	// ==========================================================
	// checks
	property p_safe_force;
		@(posedge clk_sys) disable iff (rst) safe_hold_state && !safe_q |=> en_q[5:2] == 4'hf;
	endproperty
	a_safe_force: assert property (p_safe_force) else $error("enables not forced");
	property p_rsv_en;
		@(posedge clk_sys) disable iff (rst) (en_q & ~MASK_CHANNEL_ENABLE) == 8'h00;
	endproperty
	a_rsv_en: assert property (p_rsv_en) else $error("reserved enable bit set");
	property p_all_off;
		@(posedge clk_sys) disable iff (rst) !en_q[ALL_ENABLE_BIT] |=> out_on == 5'h00;
	endproperty
	a_all_off: assert property (p_all_off) else $error("output on while all disabled");
	property p_ch_off;
		@(posedge clk_sys) disable iff (rst) !en_q[3] |=> !out_on[3];
	endproperty
	a_ch_off: assert property (p_ch_off) else $error("channel three on while disabled");
	property p_wd_map;
		@(posedge clk_sys) disable iff (rst)
			wd_s && map_q[WATCHDOG_MAP_BIT] |=> !system_reset_output_n;
	endproperty
	a_wd_map: assert property (p_wd_map) else $error("watchdog not mapped to reset");
	property p_ch_map;
		@(posedge clk_sys) disable iff (rst)
			|((low_s | high_s) & map_q[5:1]) |=> !system_reset_output_n;
	endproperty
	a_ch_map: assert property (p_ch_map) else $error("channel fault not mapped");
	property p_low_warn;
		@(posedge clk_sys) disable iff (rst) low_s[2] |=> low_st_q[2];
	endproperty
	a_low_warn: assert property (p_low_warn) else $error("low warning lost");
	property p_high_warn;
		@(posedge clk_sys) disable iff (rst) high_s[4] |=> high_st_q[4];
	endproperty
	a_high_warn: assert property (p_high_warn) else $error("high warning lost");
	property p_off;
		@(posedge clk_sys) disable iff (rst) off_s[5] |=> off_st_q[5];
	endproperty
	a_off: assert property (p_off) else $error("shutdown flag lost");
	property p_rc;
		@(posedge clk_sys) disable iff (rst)
			reg_rd && reg_addr == ADDR_SHUTDOWN_STATUS && off_s == 5'h00 |=> off_st_q == 8'h00;
	endproperty
	a_rc: assert property (p_rc) else $error("status not cleared by read");
	property p_filt;
		@(posedge clk_sys) disable iff (rst) !low_raw |=> !low_filt_q;
	endproperty
	a_filt: assert property (p_filt) else $error("filtered low without cause");
	property p_seq_hold;
		@(posedge clk_sys) disable iff (rst)
			seq_q == PCEFS_SEQ_RUN && elapsed_q < dly[2] && !sequence_start |=> !out_on[2];
	endproperty
	a_seq_hold: assert property (p_seq_hold) else $error("channel two early");
	c_safe: cover property (@(posedge clk_sys) safe_hold_state && !safe_q);
	c_seq: cover property (@(posedge clk_sys) seq_q == PCEFS_SEQ_DONE);
	c_rst: cover property (@(posedge clk_sys) !system_reset_output_n);
endmodule : pcefs_regs

// ===== tb/pcefs_host.sv
/*
 * Host model: issues register writes and reads to the bank.
 * Assumes strobes are sampled on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
module pcefs_host (
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata
);
	initial
	begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end
	// =========================================================
	// bus cycles
	// enables are also rewritten in normal run, while the turn-on sequence is still running
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		// registered data lands on the edge that takes the read
		#1 v = reg_rdata;
	endtask : rd
endmodule : pcefs_host

// ===== tb/tb_top.sv
/*
 * Self-checking bench for the register bank.
 * Assumes a 100 MHz clock and the host model in pcefs_host.
 */
`timescale 1ns/1ps
module tb_top;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic       safe_hold_state = 1'b0;
	logic       sequence_start = 1'b0;
	logic [1:0] delay_step_select = 2'b00;
	logic [4:0] glitch_filter_count = 5'h00;
	logic       glitch_filter_step = 1'b0;
	logic [5:1] low_cmp = 5'h00, high_cmp = 5'h00, shutdown_cmp = 5'h00;
	logic       watchdog_error = 1'b0;
	logic [5:1] out_on;
	logic       system_reset_output_n;
	int         fail_count = 0, checked = 0, n;
	logic [7:0] addr_tab [8] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h09};
	logic [7:0] rst_tab  [8] = '{8'h3d, 8'h00, 8'h11, 8'h3f, 8'h00, 8'h00, 8'h00, 8'h00};

	always #5 clk_sys = ~clk_sys;

	pcefs_host u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	pcefs_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.safe_hold_state(safe_hold_state), .sequence_start(sequence_start),
		.delay_step_select(delay_step_select), .glitch_filter_count(glitch_filter_count),
		.glitch_filter_step(glitch_filter_step), .low_cmp(low_cmp), .high_cmp(high_cmp),
		.shutdown_cmp(shutdown_cmp), .watchdog_error(watchdog_error), .out_on(out_on),
		.system_reset_output_n(system_reset_output_n));

	// =========================================================
	// checking and closing
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	// comparator pulse held for hold cycles, then the status read
	task automatic fault(input int k, input logic [5:1] b, input int hold,
		input logic [7:0] a, input logic [7:0] e);
		if (k == 0)
			low_cmp <= b;
		else if (k == 1)
			high_cmp <= b;
		else
			shutdown_cmp <= b;
		repeat (hold) @(posedge clk_sys);
		low_cmp      <= 5'h00;
		high_cmp     <= 5'h00;
		shutdown_cmp <= 5'h00;
		repeat (5) @(posedge clk_sys);
		u_host.rd(a, d);
		check(d, e);
	endtask : fault

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		fail_count++;
		stop_test();
	end

	// =========================================================
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		foreach (addr_tab[i])
		begin
			u_host.rd(addr_tab[i], d);
			check(d, rst_tab[i]);
		end
		u_host.wr(8'h05, 8'hff);
		u_host.rd(8'h05, d);
		check(d, 8'h3d);
		u_host.wr(8'h08, 8'hff);
		u_host.rd(8'h08, d);
		check(d, 8'h3f);
		u_host.wr(8'h06, 8'ha5);
		u_host.wr(8'h07, 8'h5a);
		u_host.rd(8'h06, d);
		check(d, 8'ha5);
		u_host.rd(8'h07, d);
		check(d, 8'h5a);
		u_host.wr(8'h0a, 8'hff);
		u_host.rd(8'h0a, d);
		check(d, 8'h00);
		u_host.wr(8'h05, 8'h01);
		u_host.rd(8'h05, d);
		check(d, 8'h01);
		safe_hold_state <= 1'b1;
		@(posedge clk_sys);
		safe_hold_state <= 1'b0;
		u_host.rd(8'h05, d);
		check(d, 8'h3d);
		// one 0.5 ms step for out2, zero for the rest
		u_host.wr(8'h06, 8'h00);
		u_host.wr(8'h07, 8'h01);
		sequence_start <= 1'b1;
		@(posedge clk_sys);
		sequence_start <= 1'b0;
		repeat (5) @(posedge clk_sys);
		check({3'b000, out_on}, 8'h1d);
		n = 5;
		while (out_on[2] !== 1'b1 && n < 60000)
		begin
			@(posedge clk_sys);
			n++;
		end
		check({7'h00, n > 49990 && n < 50010}, 8'h01);
		u_host.wr(8'h05, 8'h3c);
		repeat (5) @(posedge clk_sys);
		check({3'b000, out_on}, 8'h00);
		u_host.wr(8'h05, 8'h3d);
		// status registers
		fault(0, 5'b00100, 5, 8'h0a, 8'h88);
		u_host.rd(8'h0a, d);
		check(d, 8'h00);
		fault(1, 5'b00001, 5, 8'h0b, 8'h82);
		fault(2, 5'b10000, 5, 8'h0c, 8'h20);
		glitch_filter_count <= 5'h02;
		fault(0, 5'b00001, 100, 8'h0a, 8'h02);
		fault(0, 5'b00001, 1000, 8'h0a, 8'h82);
		glitch_filter_step <= 1'b1;
		fault(0, 5'b00001, 900, 8'h0a, 8'h02);
		fault(0, 5'b00001, 2500, 8'h0a, 8'h82);
		glitch_filter_count <= 5'h00;
		u_host.wr(8'h05, 8'h35);
		fault(0, 5'b00100, 5, 8'h0a, 8'h08);
		// reset routing
		watchdog_error <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check({7'h00, system_reset_output_n}, 8'h00);
		u_host.wr(8'h08, 8'h3e);
		repeat (5) @(posedge clk_sys);
		check({7'h00, system_reset_output_n}, 8'h01);
		watchdog_error <= 1'b0;
		high_cmp       <= 5'b00001;
		repeat (5) @(posedge clk_sys);
		check({7'h00, system_reset_output_n}, 8'h00);
		u_host.wr(8'h08, 8'h3c);
		repeat (5) @(posedge clk_sys);
		check({7'h00, system_reset_output_n}, 8'h01);
		u_host.rd(8'h0b, d);
		u_host.rd(8'h0b, d);
		check(d, 8'h82);
		high_cmp <= 5'h00;
		stop_test();
	end
endmodule : tb_top
